// ==== mshub_map.vh ====
`ifndef MSHUB_MAP_VH
`define MSHUB_MAP_VH

// Geometry
`define MSHUB_NCORES 8
`define MSHUB_NPINS 32
`define MSHUB_BOOT_LSB 28
`define MSHUB_BOOT_PINS 4

// Hub timing in system clocks
`define MSHUB_ROTATION 16
`define MSHUB_EXEC_CYCLES 8

// Register byte offsets
`define MSHUB_CTRL 8'h00
`define MSHUB_STATUS 8'h04
`define MSHUB_CORE_RUN 8'h08
`define MSHUB_PIN_IN 8'h0c
`define MSHUB_PIN_DIR 8'h10
`define MSHUB_PIN_OUT 8'h14
`define MSHUB_HUB_STATE 8'h18
`define MSHUB_DIR_BASE 3'b010
`define MSHUB_OUT_BASE 3'b011

// Control fields
`define MSHUB_CTRL_REBOOT 0
`define MSHUB_CTRL_BOEN 1
`define MSHUB_CTRL_BOOT 2

// Reset values
`define MSHUB_BOEN_RST 1'b1
`define MSHUB_CORE_RUN_RST 8'h01

// Bus responses
`define MSHUB_OKAY 2'b00
`define MSHUB_SLVERR 2'b10

`endif

// ==== mshub_core_port.v ====
`timescale 1ns/1ps
`include "mshub_map.vh"

module mshub_core_port #(
  parameter NP = `MSHUB_NPINS,
  parameter [3:0] EXEC = `MSHUB_EXEC_CYCLES
) (
  input wire aclk,
  input wire aresetn,
  input wire active,
  input wire slot_start,
  input wire hub_req,
  input wire dir_we,
  input wire [NP-1:0] dir_wdata,
  input wire out_we,
  input wire [NP-1:0] out_wdata,
  input wire [NP-1:0] ctr_bits,
  input wire [NP-1:0] vid_bits,
  output reg [NP-1:0] dir,
  output reg [NP-1:0] outr,
  output wire [NP-1:0] contrib,
  output wire hub_wait,
  output wire hub_exec,
  output wire hub_done
);
  localparam [1:0] ST_IDLE = 2'd0;
  localparam [1:0] ST_WAIT = 2'd1;
  localparam [1:0] ST_EXEC = 2'd2;

  reg [1:0] state;
  reg [3:0] ecnt;
  wire go;

  // A request present on the slot's first cycle starts at once
  assign go = hub_req & slot_start & active & (state != ST_EXEC);
  assign hub_exec = (state == ST_EXEC) | go;
  assign hub_done = (state == ST_EXEC) & (ecnt == EXEC - 4'd1);
  assign hub_wait = hub_req & active & ~hub_exec;

  // Hub access sequencer; only this core's slot pulse starts its execute phase
  always @(posedge aclk) begin
    if (!aresetn || !active) begin
      state <= ST_IDLE;
      ecnt <= 4'h0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (go) begin
            state <= ST_EXEC;
            ecnt <= 4'h1;
          end else if (hub_req) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (slot_start) begin
            state <= ST_EXEC;
            ecnt <= 4'h1;
          end
        end
        ST_EXEC: begin
          if (hub_done) begin
            state <= ST_IDLE;
            ecnt <= 4'h0;
          end else begin
            ecnt <= ecnt + 4'h1;
          end
        end
        default: begin
          state <= ST_IDLE;
          ecnt <= 4'h0;
        end
      endcase
    end
  end

  // Direction and output registers; a stopped core loses both
  always @(posedge aclk) begin
    if (!aresetn || !active) begin
      dir <= {NP{1'b0}};
      outr <= {NP{1'b0}};
    end else begin
      if (dir_we)
        dir <= dir_wdata;
      if (out_we)
        outr <= out_wdata;
    end
  end

  // Contribution: module bits ORed, then gated by direction
  assign contrib = (ctr_bits | vid_bits | outr) & dir & {NP{active}};
endmodule

// ==== mshub_top.v ====
// What this block does
// - Eight identical cores, numbered 0 to 7, all run on one system clock.
// - Hub grants exclusive resources one core at a time, cores 0..7 then wrap.
// - Hub runs at half rate: each core gets one slot per 16 clocks.
// - Hub access waits up to 15 clocks for its slot, executes 8: 8 to 23.
// - Access started at slot start leaves 8 free clocks before the next slot.
// - A core waiting on or using the hub never stalls any other core.
// - Pins and system counter are shared freely; other resources only via hub.
// - Each core owns a 32-bit direction and 32-bit output register.
// - Pin direction is the OR of all cores' direction registers.
// - Core output is (counter|video|output) AND direction; pins OR all cores.
// - Pin floats as input exactly when no active core sets it to output.
// - Pin high if any active driver sets high; low only if all drive low.
// - Direction bit 1 means output, 0 means input.
// - A stopped core has direction and output contribution forced to zero.
// - Each core can read the live level of every pin, any direction.
// - Pins 28 to 31 serve boot functions only at startup, then general use.
// - Shutdown stops the internal clock, halts cores, floats every pin.
// - Shutdown on enabled brown-out, external reset low or a restart request.
// - Shutdown ends only when no enabled brown-out remains and external reset is high.
// - While external reset is low all cores are off and pins float.
`timescale 1ns/1ps
`include "mshub_map.vh"

module mshub_top #(
  parameter NC = `MSHUB_NCORES,
  parameter NP = `MSHUB_NPINS,
  parameter AW = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [AW-1:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [AW-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire [NC-1:0] core_hub_req,
  output wire [NC-1:0] core_slot_start,
  output wire [NC-1:0] core_hub_wait,
  output wire [NC-1:0] core_hub_exec,
  output wire [NC-1:0] core_hub_done,
  output wire [2:0] hub_owner,
  output wire [NC-1:0] core_active,
  input wire [NC-1:0] core_dir_we,
  input wire [NC*NP-1:0] core_dir_wdata,
  input wire [NC-1:0] core_out_we,
  input wire [NC*NP-1:0] core_out_wdata,
  input wire [NC*NP-1:0] core_ctr_bits,
  input wire [NC*NP-1:0] core_vid_bits,
  input wire [NC-1:0] core_reboot_req,
  output wire [NP-1:0] pin_level,
  input wire [NP-1:0] pin_i,
  output reg [NP-1:0] pin_o,
  output reg [NP-1:0] pin_oe,
  input wire [`MSHUB_BOOT_PINS-1:0] boot_dir,
  input wire [`MSHUB_BOOT_PINS-1:0] boot_out,
  output wire boot_active,
  input wire external_reset_low,
  input wire brownout,
  output wire sys_clk_run,
  output wire shutdown
);
  localparam BL = `MSHUB_BOOT_LSB;
  localparam BN = `MSHUB_BOOT_PINS;

  // Pin and supply inputs cross in through two flops each
  reg [NP-1:0] pin_m;
  reg [NP-1:0] pin_s;
  reg rst_m;
  reg rst_s;
  reg bo_m;
  reg bo_s;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_m <= {NP{1'b0}};
      pin_s <= {NP{1'b0}};
      rst_m <= 1'b0;
      rst_s <= 1'b0;
      bo_m <= 1'b0;
      bo_s <= 1'b0;
    end else begin
      pin_m <= pin_i;
      pin_s <= pin_m;
      rst_m <= external_reset_low;
      rst_s <= rst_m;
      bo_m <= brownout;
      bo_s <= bo_m;
    end
  end

  // Live pin levels, readable by all cores at once whatever the direction
  assign pin_level = pin_s;

  // Free-running slot counter; two system clocks per hub cycle
  reg [3:0] slot_cnt;

  always @(posedge aclk) begin
    if (!aresetn)
      slot_cnt <= 4'h0;
    else
      slot_cnt <= slot_cnt + 4'h1;
  end

  // Owner walks 0..7 and wraps, one hub cycle (two clocks) each
  assign hub_owner = slot_cnt[3:1];

  // Control state held in software-visible registers
  reg ctrl_boen;
  reg soft_reboot;
  reg [NC-1:0] core_run;
  reg boot_flag;
  reg shut;

  wire bo_hit;
  wire enter_shut;
  wire leave_ok;

  assign bo_hit = ctrl_boen & bo_s;
  assign enter_shut = bo_hit | ~rst_s | (|core_reboot_req) | soft_reboot;
  assign leave_ok = ~bo_hit & rst_s;
  assign shutdown = shut;
  // Clock-run gate stands in for stopping the core clock tree
  assign sys_clk_run = ~shut;
  assign core_active = core_run & {NC{~shut}};
  assign boot_active = boot_flag & ~shut;

  // AXI write channel holding registers
  reg aw_hold;
  reg w_hold;
  reg [AW-1:0] wr_addr;
  reg [31:0] wr_data;
  reg wr_lane0;
  wire do_write;

  assign s_axi_awready = ~aw_hold & ~s_axi_bvalid;
  assign s_axi_wready = ~w_hold & ~s_axi_bvalid;
  assign do_write = aw_hold & w_hold & ~s_axi_bvalid;

  // Write decode: only byte lane 0 carries control bits
  wire wr_ctrl;
  wire wr_run;
  wire wr_known;

  assign wr_ctrl = do_write & (wr_addr == `MSHUB_CTRL) & wr_lane0;
  assign wr_run = do_write & (wr_addr == `MSHUB_CORE_RUN) & wr_lane0;
  assign wr_known = (wr_addr == `MSHUB_CTRL) | (wr_addr == `MSHUB_CORE_RUN);

  // Shutdown state machine; a restart request wins over a clean exit
  always @(posedge aclk) begin
    if (!aresetn) begin
      shut <= 1'b1;
      core_run <= {NC{1'b0}};
      boot_flag <= 1'b0;
    end else if (shut) begin
      core_run <= {NC{1'b0}};
      if (leave_ok && !enter_shut) begin
        shut <= 1'b0;
        core_run <= `MSHUB_CORE_RUN_RST;
        boot_flag <= 1'b1;
      end
    end else if (enter_shut) begin
      shut <= 1'b1;
      core_run <= {NC{1'b0}};
      boot_flag <= 1'b0;
    end else begin
      if (wr_run)
        core_run <= wr_data[NC-1:0];
      // Boot functions end when software says startup is over
      if (wr_ctrl && wr_data[`MSHUB_CTRL_BOOT])
        boot_flag <= 1'b0;
    end
  end

  // Control register and self-clearing restart pulse
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_boen <= `MSHUB_BOEN_RST;
      soft_reboot <= 1'b0;
    end else begin
      soft_reboot <= wr_ctrl & wr_data[`MSHUB_CTRL_REBOOT];
      if (wr_ctrl)
        ctrl_boen <= wr_data[`MSHUB_CTRL_BOEN];
    end
  end

  // Per-core hub ports and pin registers
  wire [NC*NP-1:0] dir_all;
  wire [NC*NP-1:0] out_all;
  wire [NC*NP-1:0] contrib_all;

  genvar gi;
  generate
    for (gi = 0; gi < NC; gi = gi + 1) begin : g_core
      localparam [2:0] IDX = gi;
      // Slot starts on the even clock of this core's hub cycle
      assign core_slot_start[gi] = (slot_cnt[3:1] == IDX) & ~slot_cnt[0];

      // Identical per-core logic, so no core can block another
      mshub_core_port #(
        .NP(NP)
      ) u_port (
        .aclk(aclk),
        .aresetn(aresetn),
        .active(core_active[gi]),
        .slot_start(core_slot_start[gi]),
        .hub_req(core_hub_req[gi]),
        .dir_we(core_dir_we[gi]),
        .dir_wdata(core_dir_wdata[gi*NP +: NP]),
        .out_we(core_out_we[gi]),
        .out_wdata(core_out_wdata[gi*NP +: NP]),
        .ctr_bits(core_ctr_bits[gi*NP +: NP]),
        .vid_bits(core_vid_bits[gi*NP +: NP]),
        .dir(dir_all[gi*NP +: NP]),
        .outr(out_all[gi*NP +: NP]),
        .contrib(contrib_all[gi*NP +: NP]),
        .hub_wait(core_hub_wait[gi]),
        .hub_exec(core_hub_exec[gi]),
        .hub_done(core_hub_done[gi])
      );
    end
  endgenerate

  // Merge all cores; pins need no arbitration, every core reaches them
  reg [NP-1:0] mdir;
  reg [NP-1:0] mout;
  integer ci;

  always @* begin
    mdir = {NP{1'b0}};
    mout = {NP{1'b0}};
    for (ci = 0; ci < NC; ci = ci + 1) begin
      mdir = mdir | dir_all[ci*NP +: NP];
      mout = mout | contrib_all[ci*NP +: NP];
    end
    // Boot pins follow the loader only during startup
    if (boot_active) begin
      mdir[BL +: BN] = boot_dir;
      mout[BL +: BN] = boot_out & boot_dir;
    end
  end

  // Registered pin drive; nothing drives after shutdown hits
  always @(posedge aclk) begin
    if (!aresetn) begin
      pin_oe <= {NP{1'b0}};
      pin_o <= {NP{1'b0}};
    end else if (shut) begin
      pin_oe <= {NP{1'b0}};
      pin_o <= {NP{1'b0}};
    end else begin
      // A set direction bit enables the driver, clear leaves it floating
      pin_oe <= mdir;
      pin_o <= mout & mdir;
    end
  end

  // AXI write: address and data taken in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      wr_addr <= {AW{1'b0}};
      wr_data <= 32'h0000_0000;
      wr_lane0 <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `MSHUB_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold <= 1'b1;
        wr_data <= s_axi_wdata;
        wr_lane0 <= s_axi_wstrb[0];
      end
      if (do_write) begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_known ? `MSHUB_OKAY : `MSHUB_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Read decode; per-core registers occupy two 32-byte windows
  reg [31:0] rd_val;
  reg rd_ok;
  wire [2:0] rd_core;

  assign rd_core = s_axi_araddr[4:2];

  always @* begin
    rd_val = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == `MSHUB_CTRL) begin
      rd_val[`MSHUB_CTRL_BOEN] = ctrl_boen;
      rd_val[`MSHUB_CTRL_BOOT] = boot_flag;
    end else if (s_axi_araddr == `MSHUB_STATUS) begin
      rd_val = {22'h000000, rst_s, bo_s, shut, hub_owner, slot_cnt};
    end else if (s_axi_araddr == `MSHUB_CORE_RUN) begin
      rd_val[NC-1:0] = core_active;
    end else if (s_axi_araddr == `MSHUB_PIN_IN) begin
      rd_val[NP-1:0] = pin_s;
    end else if (s_axi_araddr == `MSHUB_PIN_DIR) begin
      rd_val[NP-1:0] = pin_oe;
    end else if (s_axi_araddr == `MSHUB_PIN_OUT) begin
      rd_val[NP-1:0] = pin_o;
    end else if (s_axi_araddr == `MSHUB_HUB_STATE) begin
      rd_val[15:0] = {core_hub_exec, core_hub_wait};
    end else if (s_axi_araddr[7:5] == `MSHUB_DIR_BASE && s_axi_araddr[1:0] == 2'b00) begin
      rd_val[NP-1:0] = dir_all[rd_core*NP +: NP];
    end else if (s_axi_araddr[7:5] == `MSHUB_OUT_BASE && s_axi_araddr[1:0] == 2'b00) begin
      rd_val[NP-1:0] = out_all[rd_core*NP +: NP];
    end else begin
      rd_ok = 1'b0;
    end
  end

  // AXI read: one outstanding read, answered on the next edge
  assign s_axi_arready = ~s_axi_rvalid;

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= `MSHUB_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_ok ? `MSHUB_OKAY : `MSHUB_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Mutually exclusive resources live in the cores' hub path only
  // (hub_exec/hub_done); pins bypass it by design.
endmodule

// ==== mshub_assertions.sv ====
`timescale 1ns/1ps

module mshub_assertions #(
  parameter NC = 8,
  parameter NP = 32
) (
  input wire aclk,
  input wire aresetn,
  input wire [NC-1:0] core_hub_req,
  input wire [NC-1:0] core_slot_start,
  input wire [NC-1:0] core_hub_exec,
  input wire [NC-1:0] core_hub_done,
  input wire [2:0] hub_owner,
  input wire [NC-1:0] core_active,
  input wire [NP-1:0] pin_o,
  input wire [NP-1:0] pin_oe,
  input wire external_reset_low,
  input wire brownout,
  input wire sys_clk_run,
  input wire shutdown
);
  // One clock domain; nothing is judged while reset is held
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Slot rotation and hub access timing
  a_slot_period: assert property (core_slot_start[3] |=> !core_slot_start[3] [*8] ##8 core_slot_start[3])
    else $error("slot spacing wrong");
  a_owner_order: assert property (core_slot_start[0] |-> hub_owner == 3'h0 ##2 hub_owner == 3'h1
    ##12 hub_owner == 3'h7 ##2 hub_owner == 3'h0) else $error("owner order wrong");
  a_exec_len: assert property (core_slot_start[0] && core_hub_req[0] && core_active[0] |->
    !core_hub_done[0] [*7] ##1 core_hub_done[0] && core_hub_exec[0]) else $error("execute length wrong");
  a_done_bound: assert property ($rose(core_hub_req[1]) && core_active[1] |-> ##[7:22] core_hub_done[1])
    else $error("hub access too slow");
  a_free_after: assert property (core_hub_done[0] |=> !core_hub_exec[0] [*8])
    else $error("slot gap wrong");

  // Pin merge and shutdown; boot pins excluded since the loader may drive them
  a_out_masked: assert property ((pin_o[27:0] & ~pin_oe[27:0]) == 28'h0)
    else $error("output without direction");
  a_pins_float: assert property (shutdown |=> ~|pin_oe)
    else $error("pins driven in shutdown");
  a_cores_halt: assert property (shutdown |-> ~|core_active && !sys_clk_run)
    else $error("cores run in shutdown");
  a_reset_enters: assert property (!external_reset_low [*4] |-> shutdown)
    else $error("reset pin ignored");
  a_exit_clean: assert property ($fell(shutdown) |-> $past(external_reset_low, 3) && !$past(brownout, 3))
    else $error("shutdown left early");
endmodule

bind mshub_top mshub_assertions #(.NC(NC), .NP(NP)) mshub_assertions_i (.aclk, .aresetn, .core_hub_req,
  .core_slot_start, .core_hub_exec, .core_hub_done, .hub_owner, .core_active, .pin_o, .pin_oe,
  .external_reset_low, .brownout, .sys_clk_run, .shutdown);

// ==== mshub_core_model.sv ====
`timescale 1ns/1ps

module mshub_core_model #(
  parameter NC = 8
) (
  input wire aclk,
  input wire aresetn,
  input wire [NC-1:0] start,
  input wire [NC-1:0] core_hub_done,
  output reg [NC-1:0] core_hub_req
);
  // A core holds its hub request until done, dropping it the next cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      core_hub_req <= {NC{1'b0}};
    end else begin
      core_hub_req <= (core_hub_req & ~core_hub_done) | start;
    end
  end
endmodule

// ==== mshub_tb_top.sv ====
`timescale 1ns/1ps
`include "mshub_map.vh"

// Compare two values, count it, report a mismatch at once
`define CHK(got, exp) begin \
  samples_checked = samples_checked + 1; \
  if ((got) !== (exp)) begin \
    num_errors = num_errors + 1; \
    $display("CHECK FAILED at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end

module mshub_tb_top;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
  logic s_axi_bready = 1'b1, s_axi_rready = 1'b1;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hf, boot_dir = 4'h5, boot_out = 4'h6;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata, pin_level, pin_o, pin_oe, pin_i;
  wire [7:0] core_hub_req, core_slot_start, core_hub_wait, core_hub_exec, core_hub_done, core_active;
  wire [2:0] hub_owner;
  wire boot_active, sys_clk_run, shutdown;
  logic [7:0] core_dir_we = 8'h00, core_out_we = 8'h00, core_reboot_req = 8'h00, start = 8'h00;
  logic [255:0] core_dir_wdata = 256'h0, core_out_wdata = 256'h0, core_ctr_bits = 256'h0, core_vid_bits = 256'h0;
  logic external_reset_low = 1'b1, brownout = 1'b0;
  logic [33:0] rows [0:10];
  logic [31:0] rd;
  logic [1:0] rsp;
  int num_errors = 0, samples_checked = 0, cycles = 0;

  mshub_top mshub_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_hub_req,
    .core_slot_start, .core_hub_wait, .core_hub_exec, .core_hub_done, .hub_owner, .core_active, .core_dir_we,
    .core_dir_wdata, .core_out_we, .core_out_wdata, .core_ctr_bits, .core_vid_bits, .core_reboot_req,
    .pin_level, .pin_i, .pin_o, .pin_oe, .boot_dir, .boot_out, .boot_active, .external_reset_low, .brownout,
    .sys_clk_run, .shutdown);
  mshub_core_model mshub_core_model_i (.aclk, .aresetn, .start, .core_hub_done, .core_hub_req);

  // Clock, and pins that nobody drives read as pulled high
  always #20 aclk = ~aclk;
  assign pin_i = (pin_o & pin_oe) | ~pin_oe;

  task print_verdict();
    begin
      $display("errors %0d, checks %0d", num_errors, samples_checked);
      if (num_errors == 0 && samples_checked > 0) begin
        $display("verification passed");
      end else begin
        $display("verification failed");
      end
      $finish;
    end
  endtask

  // A hang counts as a mismatch
  always @(posedge aclk) begin
    cycles = cycles + 1;
    if (cycles == 6000) begin
      num_errors = num_errors + 1;
      print_verdict();
    end
  end

  task tick(input int n);
    repeat (n) @(posedge aclk);
  endtask

  // Bus write: each valid drops at the edge its ready is seen; bready stays high
  task axi_wr(input [7:0] a, input [31:0] d, output [1:0] r);
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end while (s_axi_bvalid !== 1'b1);
      r = s_axi_bresp;
    end
  endtask

  task axi_rd(input [7:0] a, output [31:0] d, output [1:0] r);
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end while (s_axi_rvalid !== 1'b1);
      d = s_axi_rdata;
      r = s_axi_rresp;
    end
  endtask

  // Row bit per core placed on pins 12 and 30
  function [31:0] sp(input b);
    sp = {1'b0, b, 17'h0, b, 12'h0};
  endfunction

  task apply(input [33:0] r);
    int i;
    begin
      for (i = 0; i < 8; i++) begin
        core_dir_wdata[32*i+:32] <= sp(r[26+i]);
        core_out_wdata[32*i+:32] <= sp(r[18+i]);
        core_ctr_bits[32*i+:32] <= sp(r[10+i]);
        core_vid_bits[32*i+:32] <= sp(r[2+i]);
      end
      core_dir_we <= 8'hff;
      core_out_we <= 8'hff;
      tick(1);
      core_dir_we <= 8'h00;
      core_out_we <= 8'h00;
      tick(3);
    end
  endtask

  // Request just on the slot start (skew 0) or one cycle after it (skew 1)
  task hub_lat(input int c, input int skew, input int expn);
    int n;
    logic w;
    begin
      n = 0;
      do @(posedge aclk); while (core_slot_start[c] !== 1'b1);
      tick(14 + skew);
      start[c] <= 1'b1;
      tick(1);
      start[c] <= 1'b0;
      do begin
        @(posedge aclk);
        n = n + 1;
        if (n == 1) w = core_hub_wait[c];
      end while (core_hub_done[c] !== 1'b1 && n < 40);
      // n counts from the first cycle the request is seen, so it is the latency itself
      `CHK(n, expn)
      `CHK(w, skew == 1)
    end
  endtask

  // Rows: direction, output, counter, video per core, then expected pin dir and level
  initial begin
    rows = '{{8'h00, 8'h00, 8'h00, 8'h00, 2'b00}, {8'h01, 8'h00, 8'h00, 8'h00, 2'b10},
      {8'h01, 8'h01, 8'h00, 8'h00, 2'b11}, {8'h01, 8'h02, 8'h00, 8'h00, 2'b10},
      {8'h03, 8'h02, 8'h00, 8'h00, 2'b11}, {8'hff, 8'h0a, 8'h00, 8'h00, 2'b11},
      {8'hff, 8'h08, 8'h00, 8'h00, 2'b11}, {8'hf7, 8'h08, 8'h00, 8'h00, 2'b10},
      {8'h01, 8'h00, 8'h01, 8'h00, 2'b11}, {8'h01, 8'h00, 8'h00, 8'h01, 2'b11},
      {8'h01, 8'h00, 8'h02, 8'h00, 2'b10}};
    tick(15);
    `CHK({shutdown, pin_oe, core_active}, {1'b1, 32'h0, 8'h00})
    tick(1);
    aresetn <= 1'b1;
    tick(8);
    `CHK({shutdown, core_active, boot_active}, {1'b0, 8'h01, 1'b1})
    axi_wr(`MSHUB_CTRL, 32'h0000_0006, rsp);
    axi_wr(`MSHUB_CORE_RUN, 32'h0000_00ff, rsp);
    `CHK(rsp, `MSHUB_OKAY)
    axi_rd(`MSHUB_CORE_RUN, rd, rsp);
    `CHK({rd[7:0], boot_active}, {8'hff, 1'b0})
    for (int n = 0; n < 11; n++) begin
      apply(rows[n]);
      `CHK({pin_oe[30], pin_oe[12], pin_o[30], pin_o[12]}, {{2{rows[n][1]}}, {2{rows[n][0]}}})
    end
    axi_rd(`MSHUB_PIN_IN, rd, rsp);
    `CHK({rd, pin_level}, {2{32'hbfff_efff}})
    // A stopped core must let go of the pin it alone drove
    apply({8'h02, 8'h02, 16'h0, 2'b11});
    axi_wr(`MSHUB_CORE_RUN, 32'h0000_00fd, rsp);
    tick(3);
    axi_rd(8'h44, rd, rsp);
    `CHK({pin_oe[12], rd}, 33'h0)
    axi_rd(8'h30, rd, rsp);
    `CHK(rsp, `MSHUB_SLVERR)
    axi_wr(8'h30, 32'h0000_0000, rsp);
    `CHK(rsp, `MSHUB_SLVERR)
    axi_wr(`MSHUB_CORE_RUN, 32'h0000_00ff, rsp);
    for (int c = 0; c < 8; c++) begin
      hub_lat(c, c % 2, (c % 2) ? 23 : 8);
    end
    // Brown-out, reset pin and core restart each force shutdown
    for (int k = 0; k < 3; k++) begin
      core_dir_wdata[31:0] <= 32'h0000_00ff;
      core_dir_we <= 8'h01;
      tick(1);
      core_dir_we <= 8'h00;
      tick(3);
      `CHK(pin_oe[7:0], 8'hff)
      brownout <= (k == 0);
      external_reset_low <= (k != 1);
      core_reboot_req <= (k == 2) ? 8'h01 : 8'h00;
      tick(6);
      `CHK({shutdown, pin_oe, core_active}, {1'b1, 32'h0, 8'h00})
      brownout <= 1'b0;
      external_reset_low <= 1'b1;
      core_reboot_req <= 8'h00;
      tick(8);
      `CHK({shutdown, core_active}, {1'b0, 8'h01})
      `CHK({boot_active, pin_oe[31:28], pin_o[31:28]}, {1'b1, 4'h5, 4'h4})
    end
    // Software restart through the control register; shutdown lasts one cycle
    axi_wr(`MSHUB_CTRL, 32'h0000_0003, rsp);
    tick(1);
    `CHK(shutdown, 1'b1)
    tick(4);
    `CHK({shutdown, core_active}, {1'b0, 8'h01})
    // With detection disabled a brown-out is ignored
    axi_wr(`MSHUB_CTRL, 32'h0, rsp);
    brownout <= 1'b1;
    tick(6);
    `CHK(shutdown, 1'b0)
    print_verdict();
  end
endmodule
